// file: sim/ubrg_chan_model.sv
// Purpose: Behavioural transmitter and receiver shift logic of one channel.
// Assumes: Shifts once per sampling tick of the generator.
// Notes: Sends one fixed frame over and over so the output pin keeps changing.
`timescale 1ns/1ps

module ubrg_chan_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Generator side
    input wire logic sample_tick,
    input wire logic serial_in_data,
    output logic tx_serial_data,
    output logic [7:0] rx_shift
);
    // Start bit 0, data 8'hA5 sent from its low bit, stop bit 1.
    logic [9:0] frame_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_q <= 10'h34A;
            rx_shift <= 8'h00;
        end else if (sample_tick) begin
            frame_q <= {frame_q[0], frame_q[9:1]};
            rx_shift <= {serial_in_data, rx_shift[7:1]};
        end
    end

    assign tx_serial_data = frame_q[0];
endmodule

// file: sim/ubrg_top_tb.sv
// Purpose: Self-checking bench of the channel sampling clock generator.
// Assumes: Oscillators are made here as slow square waves locked to mclk.
// Notes: Intervals are timed between pulses, so the fixed sync delay cancels.
`timescale 1ns/1ps
`include "ubrg_consts.svh"

module ubrg_top_tb import ubrg_pkg::*;;
    // Oscillator periods keep every programmed rate well under the normal-mode ceiling.
    localparam int CYCLE_CEIL = 80000;
    localparam int P_IRC = 8;
    localparam int P_LSC = 12;
    localparam int P_HSC = 10;
    localparam int P_EXT = 14;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic irc = 1'b0;
    logic lsc = 1'b0;
    logic hsc = 1'b0;
    logic ext_pin = 1'b0;
    logic sin_pin = 1'b1;
    logic gpio_lvl = 1'b0;
    logic tx_data;
    ubrg_ctrl_t ctrl = '0;
    logic tick, uf, sin_data, sout, uf1;
    logic [7:0] rx_shift;
    int osc_cnt = 0;
    int cycles = 0;
    int n_errors = 0;
    int comparisons = 0;

    ubrg_top #(.HAS_HS_OSC(1'b1)) u_dut (
        .mclk(mclk), .rst(rst), .internal_rc_osc(irc), .low_speed_crystal_osc(lsc),
        .high_speed_crystal_osc(hsc), .ext_transfer_clock_pin(ext_pin),
        .serial_in_pin(sin_pin), .ctrl(ctrl), .tx_serial_data(tx_data),
        .gpio_out_level(gpio_lvl), .sample_tick(tick), .underflow_pulse(uf),
        .serial_in_data(sin_data), .serial_out_pin(sout));

    // Variant without the high-speed oscillator on the same fields, to show the copies are independent.
    ubrg_top #(.HAS_HS_OSC(1'b0)) u_dut1 (
        .mclk(mclk), .rst(rst), .internal_rc_osc(irc), .low_speed_crystal_osc(lsc),
        .high_speed_crystal_osc(hsc), .ext_transfer_clock_pin(ext_pin),
        .serial_in_pin(sin_pin), .ctrl(ctrl), .tx_serial_data(tx_data),
        .gpio_out_level(gpio_lvl), .sample_tick(), .underflow_pulse(uf1),
        .serial_in_data(), .serial_out_pin());

    ubrg_chan_model u_model (
        .mclk(mclk), .rst(rst), .sample_tick(tick), .serial_in_data(sin_data),
        .tx_serial_data(tx_data), .rx_shift(rx_shift));

    initial begin
        forever #5 mclk = ~mclk;
    end

    always @(negedge mclk) begin
        osc_cnt <= osc_cnt + 1;
        irc <= (osc_cnt % P_IRC) < (P_IRC / 2);
        lsc <= (osc_cnt % P_LSC) < (P_LSC / 2);
        hsc <= (osc_cnt % P_HSC) < (P_HSC / 2);
        ext_pin <= (osc_cnt % P_EXT) < (P_EXT / 2);
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_CEIL) begin
            n_errors = n_errors + 1;
            $display("run cut short after %0d cycles", cycles);
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            n_errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Cycles until the chosen pulse (0 underflow, 1 tick, 2 second copy), or -1.
    task automatic measure(input int sel, input int limit, output int gap);
        int n;
        logic p;
        n = 0;
        gap = -1;
        while (n < limit) begin
            @(negedge mclk);
            n++;
            p = (sel == 0) ? uf : ((sel == 1) ? tick : uf1);
            if (p === 1'b1) begin
                gap = n;
                n = limit;
            end
        end
    endtask

    // This task changes settings only with the gate closed; the pin checks later clear port_func_select with it open.
    task automatic start(input logic [1:0] src, input logic [1:0] div,
                         input logic [7:0] rld, input logic [3:0] fine, input logic ext);
        @(negedge mclk);
        ctrl.count_clock_gate = 1'b0;
        @(negedge mclk);
        ctrl.count_source_select = src;
        ctrl.prescale_ratio_select = div;
        ctrl.reload_value = rld;
        ctrl.fine_delay_pattern = fine;
        ctrl.ext_clock_select = ext;
        ctrl.port_func_select = ext;
        repeat (2) @(negedge mclk);
        ctrl.count_clock_gate = 1'b1;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        int g, e, sum, lim;
        logic prev_tx;
        repeat (10) @(negedge mclk);
        check_bit("sample_tick", 1'b0, tick);
        check_bit("underflow_pulse", 1'b0, uf);
        check_bit("serial_in_data", 1'b1, sin_data);
        check_bit("serial_out_pin", 1'b1, sout);
        rst = 1'b0;
        $display("test reset done");
        measure(0, 300, g);
        check_count("underflow gap gate off", -1, g);
        $display("test gate done");
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                e = (s == 3) ? -1 : 3 * ((s == 0) ? P_IRC : (s == 1) ? P_LSC : P_HSC);
                if (s != 1 && e > 0) e = e << d;
                lim = (e < 0) ? 400 : 3 * e + 100;
                start(2'(s), 2'(d), 8'h02, 4'h0, 1'b0);
                measure(0, lim, g);
                measure(0, lim, g);
                check_count("underflow gap by source", e, g);
                measure(2, lim, g);
                measure(2, lim, g);
                check_count("copy gap", (s == 2) ? -1 : e, g);
            end
        end
        $display("test sources done");
        for (int r = 0; r < 256; r += 255) begin
            start(2'h0, 2'h0, 8'(r), 4'h0, 1'b0);
            measure(0, 5000, g);
            measure(0, 5000, g);
            check_count("underflow gap by reload", (r + 1) * P_IRC, g);
        end
        $display("test reload done");
        for (int f = 0; f < 16; f++) begin
            start(2'h0, 2'h0, 8'h01, 4'(f), 1'b0);
            measure(1, 200, g);
            sum = 0;
            for (int k = 0; k < 16; k++) begin
                measure(1, 200, g);
                sum += g;
            end
            check_count("ticks in 16 periods", (16 * 2 + f) * P_IRC, sum);
        end
        $display("test fine done");
        start(2'h0, 2'h3, 8'h01, 4'h0, 1'b1);
        measure(1, 200, g);
        measure(1, 200, g);
        check_count("tick gap external", P_EXT, g);
        measure(0, 200, g);
        measure(0, 200, g);
        check_count("underflow gap external", 2 * P_EXT, g);
        prev_tx = tx_data;
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk);
            check_bit("serial_out_pin tx", prev_tx, sout);
            prev_tx = tx_data;
        end
        check_byte("rx_shift idle", 8'hFF, rx_shift);
        sin_pin = 1'b0;
        repeat (7) @(negedge mclk);
        check_bit("serial_in_data channel", 1'b0, sin_data);
        // Nine tick periods leave at least eight ticks after the low level arrives.
        repeat (9 * P_EXT) @(negedge mclk);
        check_byte("rx_shift low", 8'h00, rx_shift);
        ctrl.port_func_select = 1'b0;
        gpio_lvl = 1'b1;
        repeat (7) @(negedge mclk);
        check_bit("serial_in_data port", 1'b1, sin_data);
        check_bit("serial_out_pin port", 1'b1, sout);
        gpio_lvl = 1'b0;
        repeat (2) @(negedge mclk);
        check_bit("serial_out_pin port low", 1'b0, sout);
        $display("test pins done");
        end_of_test();
    end
endmodule

// file: src/ubrg_consts.svh
// Purpose: Named constants of the baud rate generator of one serial channel.
// Assumes: Included by bare name wherever a constant is needed.
// Notes: Definitions only.
`ifndef UBRG_CONSTS_SVH
`define UBRG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Count source codes
// ----------------------------------------------------------------------------
`define UBRG_SRC_IRC 2'h0
`define UBRG_SRC_LSC 2'h1
`define UBRG_SRC_HSC 2'h2
`define UBRG_SRC_RSV 2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UBRG_CNT_RST 8'h00
`define UBRG_GRP_RST 4'h0
`define UBRG_PRE_RST 3'h0
`define UBRG_SYNC_RST 3'h0
`define UBRG_PIN_IDLE 1'h1

// ----------------------------------------------------------------------------
// Counter figures
// ----------------------------------------------------------------------------
`define UBRG_CNT_ZERO 8'h00
`define UBRG_CNT_STEP 8'h01
`define UBRG_GRP_STEP 4'h1
`define UBRG_PRE_STEP 3'h1

// ----------------------------------------------------------------------------
// Prescale pass masks, one per ratio code
// ----------------------------------------------------------------------------
`define UBRG_PRE_MASK_1 3'h0
`define UBRG_PRE_MASK_2 3'h1
`define UBRG_PRE_MASK_4 3'h3
`define UBRG_PRE_MASK_8 3'h7

// ----------------------------------------------------------------------------
// Fine delay patterns: bit n set stretches underflow n+1 of each group of 16
// ----------------------------------------------------------------------------
`define UBRG_FMD_0 16'h0000
`define UBRG_FMD_1 16'h8000
`define UBRG_FMD_2 16'h8080
`define UBRG_FMD_3 16'h8880
`define UBRG_FMD_4 16'h8888
`define UBRG_FMD_5 16'hA888
`define UBRG_FMD_6 16'hA8A8
`define UBRG_FMD_7 16'hAAA8
`define UBRG_FMD_8 16'hAAAA
`define UBRG_FMD_9 16'hEAAA
`define UBRG_FMD_10 16'hEAEA
`define UBRG_FMD_11 16'hEEEA
`define UBRG_FMD_12 16'hEEEE
`define UBRG_FMD_13 16'hFEEE
`define UBRG_FMD_14 16'hFEFE
`define UBRG_FMD_15 16'hFFFE

`endif

// file: src/ubrg_edge_sync.sv
// Purpose: Brings one asynchronous pin into the mclk domain and flags its rise.
// Assumes: The pin is slow next to mclk, each level lasting several cycles.
// Notes: A level counts once the second and third stages agree.
`timescale 1ns/1ps
`include "ubrg_consts.svh"

module ubrg_edge_sync import ubrg_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pin side
    input wire logic pin,
    // Synchronised side
    output logic level,
    output logic rise
);

    ubrg_sync_t s_q;
    ubrg_sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.sh = {s_q.sh[1:0], pin};
        s_d.rise = 1'b0;
        // The first stage feeds only the second; the filter looks at stages two and three.
        if (s_q.sh[1] == s_q.sh[2]) begin
            s_d.level = s_q.sh[2];
            s_d.rise = s_q.sh[2] & ~s_q.level;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{sh: `UBRG_SYNC_RST, level: 1'b0, rise: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.level;
    assign rise = s_q.rise;

endmodule

// file: src/ubrg_pkg.sv
// Purpose: Types shared by the baud rate generator files.
// Assumes: Nothing beyond the constants header.
// Notes: Holds types only; numbers live in the constants header.
package ubrg_pkg;

    // ------------------------------------------------------------------------
    // Software control fields of one channel
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] count_source_select;
        logic [1:0] prescale_ratio_select;
        logic count_clock_gate;
        logic [7:0] reload_value;
        logic [3:0] fine_delay_pattern;
        logic ext_clock_select;
        logic port_func_select;
    } ubrg_ctrl_t;

    // ------------------------------------------------------------------------
    // Counter phase, Gray coded along idle, count, stretch
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        UBRG_PH_IDLE = 2'h0,
        UBRG_PH_COUNT = 2'h1,
        UBRG_PH_STRETCH = 2'h3
    } ubrg_phase_t;

    // ------------------------------------------------------------------------
    // State of the pin synchroniser
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sh;
        logic level;
        logic rise;
    } ubrg_sync_t;

    // ------------------------------------------------------------------------
    // State of the generator
    // ------------------------------------------------------------------------
    typedef struct packed {
        ubrg_phase_t phase;
        logic [7:0] cnt;
        logic [3:0] grp;
        logic [2:0] pre;
        logic uf;
        logic tick;
        logic sout;
        logic sin;
    } ubrg_state_t;

endpackage

// file: src/ubrg_top.sv
// Purpose: Sampling clock generator and pin routing of one serial channel.
// Assumes: Oscillators and the external clock pin are asynchronous to mclk.
// Notes: Each channel instantiates its own copy; its control fields and HAS_HS_OSC can differ.
//
// Overview of operation
// - A 2-bit code picks internal, low-speed or high-speed source, rest reserved; reset 0.
// - A 2-bit code divides the internal and high-speed sources by 1, 2, 4 or 8; reset 0.
// - The gate bit, reset 0, passes the count clock to the counter only while set.
// - An 8-bit counter counts down and flags underflow when it passes below zero.
// - Every underflow reloads the counter with the programmed value.
// - The reload value is an 8-bit software field from 0 to 255.
// - Sixteen underflow periods last sixteen times reload plus one, plus the fine setting, count clocks.
// - The channel's sampling clock comes from the generator or from the external clock pin.
// - Each channel has an independent copy of this logic; HAS_HS_OSC may differ between copies.
// - After reset the serial pins stay general-purpose until the port function is selected.
// - A 4-bit fine code stretches 0 to 15 of each 16 underflow periods by one count clock.
`timescale 1ns/1ps
`include "ubrg_consts.svh"

module ubrg_top import ubrg_pkg::*; #(
    parameter bit HAS_HS_OSC = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Oscillators and pins
    input wire logic internal_rc_osc,
    input wire logic low_speed_crystal_osc,
    input wire logic high_speed_crystal_osc,
    input wire logic ext_transfer_clock_pin,
    input wire logic serial_in_pin,
    // Control fields
    input wire ubrg_ctrl_t ctrl,
    // Channel and port side
    input wire logic tx_serial_data,
    input wire logic gpio_out_level,
    output logic sample_tick,
    output logic underflow_pulse,
    output logic serial_in_data,
    output logic serial_out_pin
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic irc_rise;
    logic lsc_rise;
    logic hsc_rise;
    logic ext_rise;
    logic sin_level;

    ubrg_edge_sync u_irc (.mclk(mclk), .rst(rst), .pin(internal_rc_osc), .level(),
        .rise(irc_rise));
    ubrg_edge_sync u_lsc (.mclk(mclk), .rst(rst), .pin(low_speed_crystal_osc), .level(),
        .rise(lsc_rise));
    ubrg_edge_sync u_hsc (.mclk(mclk), .rst(rst), .pin(high_speed_crystal_osc), .level(),
        .rise(hsc_rise));
    ubrg_edge_sync u_ext (.mclk(mclk), .rst(rst), .pin(ext_transfer_clock_pin), .level(),
        .rise(ext_rise));
    ubrg_edge_sync u_sin (.mclk(mclk), .rst(rst), .pin(serial_in_pin), .level(sin_level),
        .rise());

    // ------------------------------------------------------------------------
    // Lookups
    // ------------------------------------------------------------------------
    function automatic logic [15:0] fmd_pattern(input logic [3:0] code);
        case (code)
            4'h0: fmd_pattern = `UBRG_FMD_0;
            4'h1: fmd_pattern = `UBRG_FMD_1;
            4'h2: fmd_pattern = `UBRG_FMD_2;
            4'h3: fmd_pattern = `UBRG_FMD_3;
            4'h4: fmd_pattern = `UBRG_FMD_4;
            4'h5: fmd_pattern = `UBRG_FMD_5;
            4'h6: fmd_pattern = `UBRG_FMD_6;
            4'h7: fmd_pattern = `UBRG_FMD_7;
            4'h8: fmd_pattern = `UBRG_FMD_8;
            4'h9: fmd_pattern = `UBRG_FMD_9;
            4'hA: fmd_pattern = `UBRG_FMD_10;
            4'hB: fmd_pattern = `UBRG_FMD_11;
            4'hC: fmd_pattern = `UBRG_FMD_12;
            4'hD: fmd_pattern = `UBRG_FMD_13;
            4'hE: fmd_pattern = `UBRG_FMD_14;
            default: fmd_pattern = `UBRG_FMD_15;
        endcase
    endfunction

    function automatic logic [2:0] pre_mask(input logic [1:0] code);
        case (code)
            2'h0: pre_mask = `UBRG_PRE_MASK_1;
            2'h1: pre_mask = `UBRG_PRE_MASK_2;
            2'h2: pre_mask = `UBRG_PRE_MASK_4;
            default: pre_mask = `UBRG_PRE_MASK_8;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------------------
    ubrg_state_t s_q;
    ubrg_state_t s_d;
    logic raw_tick;
    logic divisible;
    logic cnt_tick;
    logic fire;
    logic [15:0] pattern;

    always_comb begin
        raw_tick = 1'b0;
        divisible = 1'b0;
        if (ctrl.ext_clock_select) begin
            raw_tick = ext_rise & ctrl.port_func_select;
        end else begin
            case (ctrl.count_source_select)
                `UBRG_SRC_IRC: begin
                    raw_tick = irc_rise;
                    divisible = 1'b1;
                end
                `UBRG_SRC_LSC: begin
                    raw_tick = lsc_rise;
                end
                `UBRG_SRC_HSC: begin
                    raw_tick = hsc_rise & HAS_HS_OSC;
                    divisible = 1'b1;
                end
                default: begin
                    raw_tick = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.uf = 1'b0;
        s_d.tick = 1'b0;
        fire = 1'b0;
        pattern = fmd_pattern(ctrl.fine_delay_pattern);
        // Only the divisible sources see the prescaler; the others pass every edge.
        cnt_tick = raw_tick & ctrl.count_clock_gate;
        if (divisible) begin
            cnt_tick = cnt_tick &
                ((s_q.pre & pre_mask(ctrl.prescale_ratio_select)) ==
                pre_mask(ctrl.prescale_ratio_select));
            if (raw_tick & ctrl.count_clock_gate) begin
                s_d.pre = s_q.pre + `UBRG_PRE_STEP;
            end
        end
        if (!ctrl.count_clock_gate) begin
            // A stopped counter holds the reload value so the first period is full.
            s_d.phase = UBRG_PH_IDLE;
            s_d.cnt = ctrl.reload_value;
            s_d.grp = `UBRG_GRP_RST;
            s_d.pre = `UBRG_PRE_RST;
        end else begin
            case (s_q.phase)
                UBRG_PH_IDLE: begin
                    s_d.phase = UBRG_PH_COUNT;
                    s_d.cnt = ctrl.reload_value;
                end
                UBRG_PH_COUNT: begin
                    if (cnt_tick) begin
                        if (s_q.cnt == `UBRG_CNT_ZERO) begin
                            if (pattern[s_q.grp]) begin
                                s_d.phase = UBRG_PH_STRETCH;
                            end else begin
                                fire = 1'b1;
                            end
                        end else begin
                            s_d.cnt = s_q.cnt - `UBRG_CNT_STEP;
                        end
                    end
                end
                UBRG_PH_STRETCH: begin
                    fire = cnt_tick;
                end
                default: begin
                    s_d.phase = UBRG_PH_IDLE;
                end
            endcase
        end
        if (fire) begin
            s_d.uf = 1'b1;
            s_d.cnt = ctrl.reload_value;
            s_d.grp = s_q.grp + `UBRG_GRP_STEP;
            s_d.phase = UBRG_PH_COUNT;
        end
        // The external pin, once selected with port_func_select set, is the sampling clock itself.
        s_d.tick = ctrl.ext_clock_select ? raw_tick : fire;
        s_d.sout = ctrl.port_func_select ? tx_serial_data : gpio_out_level;
        s_d.sin = ctrl.port_func_select ? sin_level : `UBRG_PIN_IDLE;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{phase: UBRG_PH_IDLE, cnt: `UBRG_CNT_RST, grp: `UBRG_GRP_RST,
                pre: `UBRG_PRE_RST, uf: 1'b0, tick: 1'b0, sout: `UBRG_PIN_IDLE,
                sin: `UBRG_PIN_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_tick = s_q.tick;
    assign underflow_pulse = s_q.uf;
    assign serial_in_data = s_q.sin;
    assign serial_out_pin = s_q.sout;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_gate_blocks_count: assert property (@(posedge mclk) disable iff (rst)
        !ctrl.count_clock_gate |=> !underflow_pulse)
        else $error("underflow while the count clock is gated off");

    a_reload_on_underflow: assert property (@(posedge mclk) disable iff (rst)
        (underflow_pulse && $stable(ctrl.reload_value)) |-> s_q.cnt == ctrl.reload_value)
        else $error("counter not reloaded on underflow");

    a_underflow_from_zero: assert property (@(posedge mclk) disable iff (rst)
        underflow_pulse |-> $past(s_q.cnt) == `UBRG_CNT_ZERO)
        else $error("underflow without the counter at zero");

    a_reserved_source: assert property (@(posedge mclk) disable iff (rst)
        (!ctrl.ext_clock_select && ctrl.count_source_select == `UBRG_SRC_RSV) |-> !cnt_tick)
        else $error("reserved source produced a count clock");

    a_fine_off_default: assert property (@(posedge mclk) disable iff (rst)
        (ctrl.fine_delay_pattern == 4'h0 && s_q.phase == UBRG_PH_COUNT)
        |=> s_q.phase != UBRG_PH_STRETCH)
        else $error("stretch with fine code zero");

    a_stretch_then_fire: assert property (@(posedge mclk) disable iff (rst)
        (s_q.phase == UBRG_PH_STRETCH && cnt_tick) |=> underflow_pulse)
        else $error("stretched period did not end on the next count clock");

    a_sample_from_gen: assert property (@(posedge mclk) disable iff (rst)
        ($past(!ctrl.ext_clock_select) && underflow_pulse) |-> sample_tick)
        else $error("generator underflow did not reach the sampling clock");

    // The pin flops hold their idle level through reset, so the first edge after it is skipped.
    a_pins_default: assert property (@(posedge mclk) disable iff (rst)
        (!$past(rst) && $past(!ctrl.port_func_select)) |->
        serial_out_pin == $past(gpio_out_level) && serial_in_data)
        else $error("serial pins not in port function");

    a_slow_undivided: assert property (@(posedge mclk) disable iff (rst)
        (!ctrl.ext_clock_select && ctrl.count_clock_gate &&
        ctrl.count_source_select == `UBRG_SRC_LSC) |-> cnt_tick == lsc_rise)
        else $error("low-speed source was divided");

endmodule
